/* hdl/sida_params.svh */
// Constants for the separate-I/O DRAM access block
`ifndef SIDA_PARAMS_SVH
`define SIDA_PARAMS_SVH

// ----------------------------------------------------------------------------
// Widths and counts
// ----------------------------------------------------------------------------
`define SIDA_DATA_W 18
`define SIDA_ADDR_W 21
`define SIDA_BANK_W 3
`define SIDA_BANKS 8
`define SIDA_MODE_W 18
`define SIDA_ROW_W 14
`define SIDA_MEM_ADDR_BITS 4
`define SIDA_MEM_IDX_W 10
`define SIDA_MEM_WORDS 1024
`define SIDA_SLOTS 16

// ----------------------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------------------
`define SIDA_MODE_RESET 18'h00000
`define SIDA_MODE_CFG_LSB 0
`define SIDA_MODE_BL_LSB 3
`define SIDA_MODE_MUX_BIT 5
`define SIDA_MODE_TERM_BIT 9
`define SIDA_BL_CODE_2 2'h0
`define SIDA_BL_CODE_4 2'h1
`define SIDA_BL_CODE_8 2'h2

// ----------------------------------------------------------------------------
// Burst lengths in data beats, latencies in input-clock cycles
// ----------------------------------------------------------------------------
`define SIDA_BL_2 4'h2
`define SIDA_BL_4 4'h4
`define SIDA_BL_8 4'h8
`define SIDA_RL_CFG1 4'h4
`define SIDA_RL_CFG2 4'h6
`define SIDA_RL_CFG3 4'h8
`define SIDA_RL_CFG4 4'h3
`define SIDA_RL_CFG5 4'h5
`define SIDA_MUX_EXTRA 4'h1
`define SIDA_WR_EXTRA 4'h1

`endif

/* hdl/sida_pkg.sv */
// Types shared by the separate-I/O DRAM access block
`include "sida_params.svh"

package sida_pkg;

  // --------------------------------------------------------------------------
  // Pin bundles
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic cs_n;
    logic we_n;
    logic ref_n;
    logic [`SIDA_BANK_W-1:0] bank;
    logic [`SIDA_ADDR_W-1:0] addr;
  } sida_cmd_pins_t;

  typedef struct packed {
    logic [`SIDA_DATA_W-1:0] data;
    logic write_data_mask;
  } sida_wr_pins_t;

  // --------------------------------------------------------------------------
  // Internal carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic is_write;
    logic [`SIDA_BANK_W-1:0] bank;
    logic [`SIDA_ADDR_W-1:0] addr;
  } sida_slot_t;

  typedef struct packed {
    logic valid;
    logic [`SIDA_BANK_W-1:0] bank;
    logic [`SIDA_ROW_W-1:0] row;
  } sida_refresh_t;

  typedef enum logic [1:0] {
    SIDA_KIND_READ = 2'h0,
    SIDA_KIND_WRITE = 2'h1,
    SIDA_KIND_MODE = 2'h2,
    SIDA_KIND_REFRESH = 2'h3
  } sida_kind_t;

  typedef enum logic {
    SIDA_ADDR_FIRST = 1'b0,
    SIDA_ADDR_SECOND = 1'b1
  } sida_addr_state_t;

endpackage : sida_pkg

/* hdl/sida_sync.sv */
// Two-flop synchroniser for pins sampled by the block clock
`timescale 1ns/10ps
`default_nettype none

module sida_sync #(
  parameter int W = 1
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] stage1;

  // Stage one feeds nothing but stage two
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      stage1 <= '0;
      o_sync <= '0;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end

endmodule : sida_sync

`default_nettype wire

/* hdl/sida_core.sv */
// Command, write and read data logic of the separate-I/O DRAM
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "sida_params.svh"

module sida_core (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_input_clock,
  input wire logic i_write_data_clock,
  input wire sida_pkg::sida_cmd_pins_t i_cmd,
  input wire sida_pkg::sida_wr_pins_t i_wr,
  output logic [`SIDA_DATA_W-1:0] o_q,
  output logic o_q_oe,
  output logic o_low_half_read_strobe,
  output logic o_high_half_read_strobe,
  output logic o_output_valid_flag,
  output logic o_input_termination,
  output var sida_pkg::sida_refresh_t o_refresh
);
  import sida_pkg::*;

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------
  function automatic logic [3:0] read_latency(input logic [`SIDA_MODE_W-1:0] mode);
    logic [3:0] base;
    case (mode[`SIDA_MODE_CFG_LSB +: 3])
      3'h2: base = `SIDA_RL_CFG2;
      3'h3: base = `SIDA_RL_CFG3;
      3'h4: base = `SIDA_RL_CFG4;
      3'h5: base = `SIDA_RL_CFG5;
      default: base = `SIDA_RL_CFG1;
    endcase
    return mode[`SIDA_MODE_MUX_BIT] ? base + `SIDA_MUX_EXTRA : base;
  endfunction : read_latency

  function automatic logic [3:0] write_latency(input logic [`SIDA_MODE_W-1:0] mode);
    return read_latency(mode) + `SIDA_WR_EXTRA;
  endfunction : write_latency

  function automatic logic [3:0] burst_length(input logic [`SIDA_MODE_W-1:0] mode);
    case (mode[`SIDA_MODE_BL_LSB +: 2])
      `SIDA_BL_CODE_4: return `SIDA_BL_4;
      `SIDA_BL_CODE_8: return `SIDA_BL_8;
      default: return `SIDA_BL_2;
    endcase
  endfunction : burst_length

  // Rebuilds the flat address from the two halves
  function automatic logic [`SIDA_ADDR_W-1:0] join_halves(
    input logic [`SIDA_ADDR_W-1:0] ax,
    input logic [`SIDA_ADDR_W-1:0] ay
  );
    logic [`SIDA_ADDR_W-1:0] a;
    a = ax;
    a[20] = ay[0];
    a[1] = ay[3];
    a[2] = ay[4];
    a[6] = ay[8];
    a[7] = ay[9];
    a[19] = ay[10];
    a[11] = ay[13];
    a[12] = ay[14];
    a[16] = ay[17];
    a[15] = ay[18];
    return a;
  endfunction : join_halves

  // Only the low address bits reach the small array
  function automatic logic [`SIDA_MEM_IDX_W-1:0] mem_index(
    input logic [`SIDA_BANK_W-1:0] bank,
    input logic [`SIDA_ADDR_W-1:0] addr,
    input logic [2:0] beat
  );
    return {bank, addr[`SIDA_MEM_ADDR_BITS-1:0], beat};
  endfunction : mem_index

  // --------------------------------------------------------------------------
  // Pin sampling
  // --------------------------------------------------------------------------
  localparam int PIN_W = $bits(sida_cmd_pins_t) + $bits(sida_wr_pins_t) + 2;

  logic [PIN_W-1:0] pins_s;
  sida_cmd_pins_t cmd_s;
  sida_cmd_pins_t cmd_p;
  sida_wr_pins_t wr_s;
  sida_wr_pins_t wr_p;
  logic ck_s;
  logic ck_p;
  logic dk_s;
  logic dk_p;
  // Edges wait until both sync stages and the prior sample hold real pins
  logic [2:0] pins_live;

  sida_sync #(.W(PIN_W)) u_pin_sync (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_async({i_cmd, i_wr, i_input_clock, i_write_data_clock}),
    .o_sync(pins_s)
  );

  assign {cmd_s, wr_s, ck_s, dk_s} = pins_s;

  // Values from the sample before an edge, so pins changing at the edge are safe
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cmd_p <= '0;
      wr_p <= '0;
      ck_p <= 1'b0;
      dk_p <= 1'b0;
      pins_live <= 3'h0;
    end else begin
      pins_live <= {pins_live[1:0], 1'b1};
      cmd_p <= cmd_s;
      wr_p <= wr_s;
      ck_p <= ck_s;
      dk_p <= dk_s;
    end
  end

  logic ck_rise;
  logic ck_edge;
  logic dk_rise;
  logic dk_edge;

  assign ck_rise = ck_s & ~ck_p & pins_live[2];
  assign ck_edge = (ck_s ^ ck_p) & pins_live[2];
  assign dk_rise = dk_s & ~dk_p & pins_live[2];
  assign dk_edge = (dk_s ^ dk_p) & pins_live[2];

  // --------------------------------------------------------------------------
  // Command decode
  // --------------------------------------------------------------------------
  logic [`SIDA_MODE_W-1:0] mode;
  sida_addr_state_t addr_state;
  sida_kind_t pend_kind;
  logic [`SIDA_BANK_W-1:0] pend_bank;
  logic [`SIDA_ADDR_W-1:0] pend_ax;
  sida_slot_t slot [`SIDA_SLOTS];

  sida_kind_t cmd_kind;
  logic cmd_take;
  logic mode_load;
  logic refresh_take;
  logic slot_ins;
  sida_slot_t slot_new;
  logic [3:0] slot_pos;
  logic [3:0] lat;

  always_comb begin
    unique case ({cmd_p.we_n, cmd_p.ref_n})
      2'b00: cmd_kind = SIDA_KIND_MODE;
      2'b01: cmd_kind = SIDA_KIND_WRITE;
      2'b10: cmd_kind = SIDA_KIND_REFRESH;
      2'b11: cmd_kind = SIDA_KIND_READ;
    endcase
  end

  always_comb begin
    cmd_take = ck_rise && addr_state == SIDA_ADDR_FIRST && !cmd_p.cs_n;
    mode_load = 1'b0;
    refresh_take = cmd_take && cmd_kind == SIDA_KIND_REFRESH;
    slot_ins = 1'b0;
    slot_new = '0;
    lat = 4'h0;
    if (ck_rise && addr_state == SIDA_ADDR_SECOND) begin
      // Second half completes a multiplexed command
      if (pend_kind == SIDA_KIND_MODE) begin
        mode_load = 1'b1;
      end else begin
        slot_ins = 1'b1;
      end
      slot_new = '{1'b1, pend_kind == SIDA_KIND_WRITE, pend_bank, join_halves(pend_ax, cmd_p.addr)};
      lat = (pend_kind == SIDA_KIND_WRITE) ? write_latency(mode) : read_latency(mode);
    end else if (cmd_take && !mode[`SIDA_MODE_MUX_BIT]) begin
      mode_load = cmd_kind == SIDA_KIND_MODE;
      slot_ins = cmd_kind == SIDA_KIND_READ || cmd_kind == SIDA_KIND_WRITE;
      slot_new = '{1'b1, cmd_kind == SIDA_KIND_WRITE, cmd_p.bank, cmd_p.addr};
      lat = (cmd_kind == SIDA_KIND_WRITE) ? write_latency(mode) : read_latency(mode);
    end
    // Entry is read from slot zero exactly lat edges after the command edge
    slot_pos = (addr_state == SIDA_ADDR_SECOND) ? lat - 4'h2 : lat - 4'h1;
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      addr_state <= SIDA_ADDR_FIRST;
      pend_kind <= SIDA_KIND_READ;
      pend_bank <= '0;
      pend_ax <= '0;
    end else if (ck_rise) begin
      unique case (addr_state)
        SIDA_ADDR_FIRST: begin
          // Refresh needs only the bank, so it never waits for a second half
          if (cmd_take && mode[`SIDA_MODE_MUX_BIT] && cmd_kind != SIDA_KIND_REFRESH) begin
            addr_state <= SIDA_ADDR_SECOND;
            pend_kind <= cmd_kind;
            pend_bank <= cmd_p.bank;
            pend_ax <= cmd_p.addr;
          end
        end
        SIDA_ADDR_SECOND: begin
          addr_state <= SIDA_ADDR_FIRST;
        end
      endcase
    end
  end

  // The first half carries every mode bit, so both formats load from it
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mode <= `SIDA_MODE_RESET;
      o_input_termination <= 1'b0;
    end else begin
      if (mode_load) begin
        mode <= (addr_state == SIDA_ADDR_SECOND) ? pend_ax[`SIDA_MODE_W-1:0] :
                cmd_p.addr[`SIDA_MODE_W-1:0];
      end
      // Reads never switch it off on separate inputs
      o_input_termination <= mode[`SIDA_MODE_TERM_BIT];
    end
  end

  // --------------------------------------------------------------------------
  // Latency pipeline
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int i = 0; i < `SIDA_SLOTS; i++) begin
        slot[i] <= '0;
      end
    end else if (ck_rise) begin
      for (int i = 0; i < `SIDA_SLOTS - 1; i++) begin
        slot[i] <= slot[i+1];
      end
      slot[`SIDA_SLOTS-1] <= '0;
      if (slot_ins) begin
        slot[slot_pos] <= slot_new;
      end
    end
  end

  logic rd_begin;
  logic wr_begin;

  assign rd_begin = ck_rise && slot[0].valid && !slot[0].is_write;
  assign wr_begin = ck_rise && slot[0].valid && slot[0].is_write;

  // --------------------------------------------------------------------------
  // Refresh counters
  // --------------------------------------------------------------------------
  logic [`SIDA_ROW_W-1:0] ref_row [`SIDA_BANKS];

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int b = 0; b < `SIDA_BANKS; b++) begin
        ref_row[b] <= '0;
      end
      o_refresh <= '0;
    end else begin
      o_refresh.valid <= refresh_take;
      if (refresh_take) begin
        ref_row[cmd_p.bank] <= ref_row[cmd_p.bank] + 1'b1;
        o_refresh.bank <= cmd_p.bank;
        o_refresh.row <= ref_row[cmd_p.bank];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Storage and write burst
  // --------------------------------------------------------------------------
  logic [`SIDA_DATA_W-1:0] mem [`SIDA_MEM_WORDS];
  logic [3:0] wr_left;
  logic [2:0] wr_beat;
  logic wr_wait;
  logic [`SIDA_BANK_W-1:0] wr_bank;
  logic [`SIDA_ADDR_W-1:0] wr_addr;
  logic wr_take;
  logic mem_we;
  logic [`SIDA_MEM_IDX_W-1:0] mem_widx;

  always_comb begin
    wr_take = dk_edge && (wr_begin ? dk_rise : (wr_left != 4'h0 && (!wr_wait || dk_rise)));
    mem_we = wr_take && !wr_p.write_data_mask;
    mem_widx = wr_begin ? mem_index(slot[0].bank, slot[0].addr, 3'h0) :
               mem_index(wr_bank, wr_addr, wr_beat);
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_left <= 4'h0;
      wr_beat <= 3'h0;
      wr_wait <= 1'b0;
      wr_bank <= '0;
      wr_addr <= '0;
    end else if (wr_begin) begin
      wr_bank <= slot[0].bank;
      wr_addr <= slot[0].addr;
      wr_wait <= !wr_take;
      wr_left <= wr_take ? burst_length(mode) - 4'h1 : burst_length(mode);
      wr_beat <= wr_take ? 3'h1 : 3'h0;
    end else if (wr_take) begin
      wr_wait <= 1'b0;
      wr_left <= wr_left - 4'h1;
      wr_beat <= wr_beat + 3'h1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (mem_we) begin
      mem[mem_widx] <= wr_p.data;
    end
  end

  // --------------------------------------------------------------------------
  // Read burst
  // --------------------------------------------------------------------------
  logic [3:0] rd_left;
  logic [2:0] rd_beat;
  logic [`SIDA_BANK_W-1:0] rd_bank;
  logic [`SIDA_ADDR_W-1:0] rd_addr;
  logic [3:0] rd_left_after;
  logic [`SIDA_MEM_IDX_W-1:0] mem_ridx;

  always_comb begin
    rd_left_after = rd_begin ? burst_length(mode) - 4'h1 :
                    (rd_left != 4'h0 ? rd_left - 4'h1 : 4'h0);
    mem_ridx = rd_begin ? mem_index(slot[0].bank, slot[0].addr, 3'h0) :
               mem_index(rd_bank, rd_addr, rd_beat);
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rd_left <= 4'h0;
      rd_beat <= 3'h0;
      rd_bank <= '0;
      rd_addr <= '0;
      o_q <= '0;
      o_q_oe <= 1'b0;
    end else if (ck_edge) begin
      rd_left <= rd_left_after;
      if (rd_begin) begin
        rd_bank <= slot[0].bank;
        rd_addr <= slot[0].addr;
        rd_beat <= 3'h1;
      end else begin
        rd_beat <= rd_beat + 3'h1;
      end
      if (rd_begin || rd_left != 4'h0) begin
        o_q <= mem[mem_ridx];
        o_q_oe <= 1'b1;
      end else begin
        o_q_oe <= 1'b0;
      end
    end
  end

  // Flag looks one edge ahead; a start can only follow a falling edge
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_output_valid_flag <= 1'b0;
    end else if (ck_edge) begin
      o_output_valid_flag <= rd_left_after != 4'h0 ||
                             (!ck_s && slot[0].valid && !slot[0].is_write);
    end
  end

  // Both strobes follow the input clock, so data changes sit on their edges
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_low_half_read_strobe <= 1'b0;
      o_high_half_read_strobe <= 1'b0;
    end else begin
      o_low_half_read_strobe <= ck_s;
      o_high_half_read_strobe <= ck_s;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  a_wl_rl_relation: assert property (write_latency(mode) == read_latency(mode) + 4'h1)
    else $error("write latency is not read latency plus one");
  a_strobe_pair: assert property (o_low_half_read_strobe == o_high_half_read_strobe &&
      o_low_half_read_strobe == $past(ck_s))
    else $error("read strobes out of step");
  a_flag_leads_data: assert property ($rose(o_q_oe) |-> $past(o_output_valid_flag))
    else $error("valid flag did not lead read data");
  a_hiz_after_burst: assert property ((ck_edge && rd_left == 4'h0 && !rd_begin) |=> !o_q_oe)
    else $error("outputs still driven after burst");
  a_read_drives: assert property (rd_begin |=> o_q_oe && rd_left == burst_length(mode) - 4'h1)
    else $error("read burst did not start");
  a_mask_blocks: assert property ((wr_take && wr_p.write_data_mask) |-> !mem_we)
    else $error("masked beat stored");
  a_write_count: assert property ((wr_take && !wr_begin) |=> wr_left == $past(wr_left) - 4'h1)
    else $error("write beat count wrong");
  a_nop_deselect: assert property ((ck_rise && cmd_p.cs_n && addr_state == SIDA_ADDR_FIRST)
      |-> !slot_ins && !mode_load && !refresh_take)
    else $error("command taken while deselected");
  a_term_steady: assert property (!$past(mode_load, 2) |-> $stable(o_input_termination))
    else $error("termination changed without mode load");
  a_refresh_step: assert property (o_refresh.valid |->
      ref_row[o_refresh.bank] == o_refresh.row + 1'b1)
    else $error("refresh row counter did not step");
  a_mux_second: assert property ((ck_rise && addr_state == SIDA_ADDR_SECOND)
      |=> addr_state == SIDA_ADDR_FIRST)
    else $error("second address half not consumed");

endmodule : sida_core

`default_nettype wire

/* verification/sida_ctrl_model.sv */
// Controller-side model: link clocks, commands and write data bursts
`timescale 1ns/10ps
`default_nettype none

module sida_ctrl_model (
  input wire logic i_clock,
  output logic o_ck,
  output logic o_dk,
  output sida_pkg::sida_cmd_pins_t o_cmd,
  output sida_pkg::sida_wr_pins_t o_wr
);
  import sida_pkg::*;

  // --------------------------------------------------------------------------
  // Link clocks
  // --------------------------------------------------------------------------
  initial begin
    o_ck = 1'b0;
    o_dk = 1'b0;
    o_cmd = {3'h7, 3'h0, 21'h000000};
    o_wr = '0;
    forever #24 o_ck = ~o_ck;
  end

  // Quarter-cycle lag puts each write beat in the middle of its data window
  always @(o_ck) o_dk <= #12 o_ck;

  // --------------------------------------------------------------------------
  // Commands
  // --------------------------------------------------------------------------
  task automatic send(input logic we_n, input logic ref_n, input logic [2:0] b,
                      input logic [20:0] a);
    @(negedge o_ck);
    @(posedge i_clock);
    o_cmd <= {1'b0, we_n, ref_n, b, a};
  endtask : send

  // Deselect; stale address replaced by its inverse so nothing leans on it
  task automatic nop();
    @(negedge o_ck);
    @(posedge i_clock);
    o_cmd <= {3'h7, ~o_cmd.bank, ~o_cmd.addr};
  endtask : nop

  // Callers space commands per bank by waiting for each burst to finish
  task automatic wr(input logic [2:0] b, input logic [20:0] a, input logic [20:0] ay,
                    input bit mux, input logic [18:0] w0, input logic [18:0] w1,
                    input int wl);
    send(1'b0, 1'b1, b, a);
    if (mux) begin
      send(1'b1, 1'b1, b, ay);
    end
    nop();
    repeat (wl - int'(mux)) @(posedge o_ck);
    @(posedge i_clock);
    o_wr <= w0;
    @(negedge o_ck);
    @(posedge i_clock);
    o_wr <= w1;
    @(posedge o_ck);
    @(posedge i_clock);
    o_wr <= ~w1;
  endtask : wr
endmodule : sida_ctrl_model

`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench for the separate-I/O DRAM access block
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import sida_pkg::*;
  logic i_clock;
  logic i_sys_rst;
  logic ck;
  logic dk;
  sida_cmd_pins_t cmd;
  sida_wr_pins_t wrp;
  logic [17:0] q;
  logic oe;
  logic qs_lo;
  logic qs_hi;
  logic vld;
  logic term;
  sida_refresh_t rf;
  int error_cnt = 0;
  int total_checks = 0;
  int n;

  sida_ctrl_model m (.i_clock(i_clock), .o_ck(ck), .o_dk(dk), .o_cmd(cmd), .o_wr(wrp));

  sida_core DUT (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_input_clock(ck),
    .i_write_data_clock(dk), .i_cmd(cmd), .i_wr(wrp), .o_q(q), .o_q_oe(oe),
    .o_low_half_read_strobe(qs_lo), .o_high_half_read_strobe(qs_hi),
    .o_output_valid_flag(vld), .o_input_termination(term), .o_refresh(rf));

  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end

  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [17:0] seen, input logic [17:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wait_oe();
    int k = 0;
    while (oe !== 1'b1 && k < 400) begin
      @(posedge i_clock);
      k++;
    end
  endtask : wait_oe

  task automatic rd(input logic [2:0] b, input logic [20:0] a, input logic [20:0] ay,
                    input bit mux, input logic [17:0] e0, input logic [17:0] e1,
                    input int rl);
    time t0;
    m.send(1'b1, 1'b1, b, a);
    @(posedge ck) t0 = $time;
    if (mux) begin
      m.send(1'b1, 1'b1, b, ay);
    end
    m.nop();
    wait_oe();
    chk("latency", 18'(($time - t0) / 48), 18'(rl));
    chk("valid lead", vld, 18'h1);
    #7;
    chk("beat0", q, e0);
    chk("strobe rise", qs_lo, 18'h1);
    chk("strobe pair", qs_hi, qs_lo);
    #24;
    chk("beat1", q, e1);
    chk("valid drop", vld, 18'h0);
    chk("strobe fall", qs_lo, 18'h0);
    #24;
    chk("release", oe, 18'h0);
  endtask : rd

  task automatic rfchk(input logic [2:0] b, input logic [13:0] row);
    int k = 0;
    // Whole run is far shorter than the refresh window
    m.send(1'b1, 1'b0, b, 21'h1abcd);
    while (rf.valid !== 1'b1 && k < 100) begin
      @(posedge i_clock);
      k++;
    end
    chk("refresh valid", rf.valid, 18'h1);
    chk("refresh bank", rf.bank, b);
    chk("refresh row", rf.row, row);
    m.nop();
    repeat (4) @(posedge ck);
  endtask : rfchk

  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #100000;
    error_cnt++;
    end_of_test();
  end

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    i_sys_rst = 1'b1;
    repeat (16) @(posedge i_clock);
    chk("reset oe", oe, 18'h0);
    chk("reset term", term, 18'h0);
    chk("reset refresh", rf.valid, 18'h0);
    i_sys_rst <= 1'b0;
    repeat (8) @(posedge i_clock);
    m.send(1'b0, 1'b0, 3'h0, 21'h000201);
    m.nop();
    repeat (20) @(posedge i_clock);
    chk("termination", term, 18'h1);
    m.wr(3'h2, 21'h5, 21'h0, 1'b0, {18'h2a5a5, 1'b0}, {18'h15a5a, 1'b0}, 5);
    rd(3'h2, 21'h5, 21'h0, 1'b0, 18'h2a5a5, 18'h15a5a, 4);
    m.wr(3'h2, 21'h5, 21'h0, 1'b0, {18'h3ffff, 1'b0}, {18'h00000, 1'b1}, 5);
    rd(3'h2, 21'h5, 21'h0, 1'b0, 18'h3ffff, 18'h15a5a, 4);
    m.wr(3'h4, 21'h6, 21'h0, 1'b0, {18'h0c3c3, 1'b0}, {18'h03c3c, 1'b0}, 5);
    m.send(1'b1, 1'b1, 3'h2, 21'h5);
    m.send(1'b1, 1'b1, 3'h4, 21'h6);
    m.nop();
    wait_oe();
    #7;
    chk("stream0", q, 18'h3ffff);
    #24;
    chk("stream1", q, 18'h15a5a);
    #24;
    chk("stream oe", oe, 18'h1);
    chk("stream2", q, 18'h0c3c3);
    #24;
    chk("stream3", q, 18'h03c3c);
    chk("term in read", term, 18'h1);
    // Let the last streamed beat drain before counting
    repeat (20) @(posedge i_clock);
    n = 0;
    repeat (120) begin
      @(posedge i_clock);
      if (oe === 1'b1) n++;
    end
    chk("deselect", 18'(n), 18'h0);
    rfchk(3'h3, 14'h0000);
    rfchk(3'h3, 14'h0001);
    rfchk(3'h5, 14'h0000);
    // Enter two-part addressing, termination kept on
    m.send(1'b0, 1'b0, 3'h0, 21'h000221);
    m.nop();
    repeat (20) @(posedge i_clock);
    m.wr(3'h1, 21'h9, 21'h6, 1'b1, {18'h11111, 1'b0}, {18'h22222, 1'b0}, 6);
    rd(3'h1, 21'h9, 21'h6, 1'b1, 18'h11111, 18'h22222, 5);
    end_of_test();
  end
endmodule : testbench

`default_nettype wire
